// ### and_compare_unit.v
/*
 * Bitwise AND and three-way compare datapath for the sequencer.
 * Assumes operands are already resolved 32-bit words on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "interlocked_logic_call_stack_fill_map.vh"
module and_compare_unit (
    input wire [31:0] src_a,
    input wire [31:0] dst_b,
    input wire [1:0] rel,
    output wire [31:0] and_res,
    output reg rel_true
);
    assign and_res = dst_b & src_a;
    // First operand comes from the source field
    always @* begin
        case (rel)
            `REL_EQ: rel_true = (src_a == dst_b);
            `REL_GT: rel_true = ($signed(src_a) > $signed(dst_b));
            `REL_HI: rel_true = (src_a > dst_b);
            default: rel_true = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ### interlocked_logic_call_stack_fill.v
/*
 * Execute sequencer for interlocked AND, plain AND, call, stack-cache fill,
 * enter-guard clear, compare and the register-access prefix.
 * Assumes operands arrive resolved from the decode stage, a memory port on the
 * same clock that answers with MEM_ACK, and an MMU store check that is combinational.
 */
`timescale 1ns/1ps
`default_nettype none
`include "interlocked_logic_call_stack_fill_map.vh"
module interlocked_logic_call_stack_fill #(
    parameter [31:0] CACHE_CAPACITY = 32'h00000100
) (
    input wire CLK,
    input wire RST,
    input wire CE,
    input wire INSTR_VALID,
    output wire INSTR_READY,
    input wire [5:0] OPCODE,
    input wire [3:0] SUBCODE,
    input wire [2:0] PARCELS,
    input wire [3:0] SRC_MODE,
    input wire [3:0] DST_MODE,
    input wire [31:0] SRC_VAL,
    input wire [31:0] DST_VAL,
    input wire [31:0] DST_ADDR,
    input wire DST_IN_MEM,
    input wire ACC_IN_MEM,
    input wire [31:0] ACC_ADDR,
    input wire PIPE_EMPTY,
    input wire [31:0] CUR_SP,
    input wire [31:0] USER_SP,
    input wire CSP_IS_ISP,
    input wire FILL_LIMIT_LOAD,
    input wire [31:0] FILL_LIMIT_VAL,
    input wire VIRT_EN,
    input wire CHK_OK,
    input wire CHK_WALK_FAULT,
    input wire ENTER_DONE,
    input wire FETCH_FAULT,
    output wire MEM_REQ,
    output reg MEM_WR,
    output reg [31:0] MEM_ADDR,
    output reg [31:0] MEM_WDATA,
    output reg MEM_LOCK,
    input wire [31:0] MEM_RDATA,
    input wire MEM_ACK,
    input wire MEM_FAULT,
    output reg CACHE_WE,
    output reg [31:0] CACHE_ADDR,
    output reg [31:0] CACHE_DATA,
    output wire [31:0] FILL_LIMIT,
    output reg WB_VALID,
    output reg WB_TO_ACC,
    output reg [31:0] WB_DATA,
    output reg STATUS_FLAG,
    output reg ENTER_GUARD,
    output reg [31:0] PC,
    output reg PREFIX_ACTIVE,
    output reg REG_ACCESS,
    output reg [3:0] REG_SEL,
    output reg EXC_VALID,
    output reg [3:0] EXC_ID,
    output reg [31:0] EXC_PC
);
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_DRAIN = 4'h1;
    localparam [3:0] S_LOCK_RD = 4'h2;
    localparam [3:0] S_LOCK_WR = 4'h3;
    localparam [3:0] S_ACC_ST = 4'h4;
    localparam [3:0] S_ACC_WB = 4'h5;
    localparam [3:0] S_CALL_IND = 4'h6;
    localparam [3:0] S_CALL_PUSH = 4'h7;
    localparam [3:0] S_FILL_TGT = 4'h8;
    localparam [3:0] S_FILL_DEC = 4'h9;
    localparam [3:0] S_FILL_RD = 4'hA;
    localparam [3:0] S_FILL_CHK = 4'hB;

    reg [3:0] state_r;
    reg [2:0] parcels_r;
    reg [31:0] src_r, dst_r, daddr_r, aaddr_r, tgt_r, msp_r;
    reg dmem_r, amem_r, call_ind_r;
    reg [1:0] cnt_r;
    reg [31:0] pfx_pc_r;

    // Parcels are two bytes; prefix adds its own parcel to the follower
    function [31:0] next_pc;
        input [31:0] pc;
        input [2:0] parcels;
        input pfx;
        reg [3:0] adv;
        begin
            adv = {1'b0, parcels} + {3'h0, pfx};
            next_pc = pc + {27'h0, adv, 1'b0};
        end
    endfunction

    function fill_go;
        input [31:0] fill_limit_pointer;
        input [31:0] tgt;
        input [31:0] usp;
        begin
            fill_go = (fill_limit_pointer < tgt) && ((fill_limit_pointer - usp) < CACHE_CAPACITY);
        end
    endfunction

    function [2:0] cmp_decode;
        input [5:0] op;
        begin
            case (op)
                `OP_CMP_EQ_IMM, `OP_CMP_EQ_STK, `OP_CMP_EQ: cmp_decode = {1'b1, `REL_EQ};
                `OP_CMP_GT_STK, `OP_CMP_GT_IMM, `OP_CMP_GT: cmp_decode = {1'b1, `REL_GT};
                `OP_CMP_HI: cmp_decode = {1'b1, `REL_HI};
                default: cmp_decode = 3'h0;
            endcase
        end
    endfunction

    wire take = INSTR_VALID && INSTR_READY;
    wire short_form = (PARCELS == `PARCELS_SHORT);
    wire is_and_interlocked = (OPCODE == `OP_AND_LOCKED) && !short_form;
    wire is_fill_s = (OPCODE == `OP_AND_LOCKED) && short_form && (SUBCODE == `SUB_FILL_SHORT);
    wire is_fill_l = (OPCODE == `OP_LONG0) && (SUBCODE == `SUB_FILL_LONG);
    wire is_call_l = (OPCODE == `OP_LONG0) && (SUBCODE == `SUB_CALL_LONG);
    wire is_call_s = (OPCODE == `OP_CALL_SHORT);
    wire is_prefix = (OPCODE == `OP_ESCAPE) && (SUBCODE == `SUB_PREFIX);
    wire is_clear = (OPCODE == `OP_ESCAPE) && (SUBCODE == `SUB_CLEAR_GUARD);
    wire is_and_d = (OPCODE == `OP_AND_SHORT) || (OPCODE == `OP_AND_LONG);
    wire is_and_a = (OPCODE == `OP_AND_ACC_SHORT) || (OPCODE == `OP_AND_ACC_LONG);
    wire [2:0] cmp = cmp_decode(OPCODE);
    wire reg_src = PREFIX_ACTIVE && (SRC_MODE == `MODE_REGISTER);
    wire reg_dst = PREFIX_ACTIVE && (DST_MODE == `MODE_REGISTER);
    wire [3:0] reg_num = reg_src ? SRC_VAL[3:0] : DST_ADDR[3:0];
    wire [31:0] pc_exc = PREFIX_ACTIVE ? pfx_pc_r : PC;
    wire [31:0] fill_off = is_fill_s ? {20'h0, SRC_VAL[7:0], 4'h0} : SRC_VAL;
    wire [31:0] fill_raw = USER_SP + fill_off;
    wire [31:0] fill_ind = (SRC_MODE == `MODE_ABSOLUTE) ? SRC_VAL : fill_raw;
    wire fill_read = !is_fill_s &&
        ((SRC_MODE == `MODE_ABSOLUTE) || (SRC_MODE == `MODE_STACK_INDIRECT));

    wire idle_a = (state_r == S_IDLE);
    wire [31:0] alu_a = idle_a ? SRC_VAL : src_r;
    wire [31:0] alu_b = idle_a ? DST_VAL : ((state_r == S_LOCK_RD) ? MEM_RDATA : dst_r);
    wire [31:0] and_res;
    wire rel_true;

    and_compare_unit alu (
        .src_a(alu_a),
        .dst_b(alu_b),
        .rel(cmp[1:0]),
        .and_res(and_res),
        .rel_true(rel_true)
    );

    // Nothing new is admitted while a sequence is running
    assign INSTR_READY = CE && idle_a;
    assign MEM_REQ = (state_r == S_LOCK_RD) || (state_r == S_LOCK_WR) ||
        (state_r == S_ACC_ST) || (state_r == S_CALL_IND) || (state_r == S_CALL_PUSH) ||
        (state_r == S_FILL_TGT) || (state_r == S_FILL_RD);
    assign FILL_LIMIT = msp_r;

    // Rounding helper: fill granule is one 16-byte group
    wire [31:0] tgt_round = (MEM_RDATA + 32'h0000000F) & 32'hFFFFFFF0;
    wire [31:0] tgt_now = ((is_fill_s || SRC_MODE == `MODE_STACK_OFFSET) ? fill_raw : SRC_VAL);
    wire [31:0] tgt_now_r = (tgt_now + 32'h0000000F) & 32'hFFFFFFF0;

    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_r <= S_IDLE;
            parcels_r <= 3'h0;
            src_r <= 32'h0;
            dst_r <= 32'h0;
            daddr_r <= 32'h0;
            aaddr_r <= 32'h0;
            tgt_r <= 32'h0;
            msp_r <= `FILL_LIMIT_RESET;
            call_ind_r <= 1'b0;
            dmem_r <= 1'b0;
            amem_r <= 1'b0;
            cnt_r <= 2'h0;
            pfx_pc_r <= 32'h0;
            MEM_WR <= 1'b0;
            MEM_ADDR <= 32'h0;
            MEM_WDATA <= 32'h0;
            MEM_LOCK <= 1'b0;
            CACHE_WE <= 1'b0;
            CACHE_ADDR <= 32'h0;
            CACHE_DATA <= 32'h0;
            WB_VALID <= 1'b0;
            WB_TO_ACC <= 1'b0;
            WB_DATA <= 32'h0;
            STATUS_FLAG <= 1'b0;
            ENTER_GUARD <= 1'b0;
            PC <= `PC_RESET;
            PREFIX_ACTIVE <= 1'b0;
            REG_ACCESS <= 1'b0;
            REG_SEL <= 4'h0;
            EXC_VALID <= 1'b0;
            EXC_ID <= 4'h0;
            EXC_PC <= 32'h0;
        end else if (CE) begin
            WB_VALID <= 1'b0;
            CACHE_WE <= 1'b0;
            REG_ACCESS <= 1'b0;
            EXC_VALID <= 1'b0;
            // Enter completion outranks a same-cycle clear
            if (ENTER_DONE)
                ENTER_GUARD <= 1'b1;
            else if (take && is_clear)
                ENTER_GUARD <= 1'b0;
            if (FILL_LIMIT_LOAD && idle_a)
                msp_r <= FILL_LIMIT_VAL;
            case (state_r)
                S_IDLE: begin
                    if (FETCH_FAULT) begin
                        // PC already holds the next instruction address here
                        EXC_VALID <= 1'b1;
                        EXC_ID <= `EXC_FETCH_FAULT;
                        EXC_PC <= PC;
                    end else if (take) begin
                        parcels_r <= PARCELS;
                        src_r <= SRC_VAL;
                        dst_r <= DST_VAL;
                        daddr_r <= DST_ADDR;
                        dmem_r <= DST_IN_MEM;
                        amem_r <= ACC_IN_MEM;
                        aaddr_r <= ACC_ADDR;
                        if (is_prefix) begin
                            // Follower completes the pair; PC stays on the prefix
                            PREFIX_ACTIVE <= 1'b1;
                            pfx_pc_r <= PC;
                        end else if ((reg_src || reg_dst) && reg_num == 4'h0) begin
                            EXC_VALID <= 1'b1;
                            EXC_ID <= `EXC_UNIMPLEMENTED;
                            EXC_PC <= pc_exc;
                            PREFIX_ACTIVE <= 1'b0;
                        end else begin
                            if (reg_src || reg_dst) begin
                                // Only mode 7 is remapped; word modes pass as usual
                                REG_ACCESS <= 1'b1;
                                REG_SEL <= reg_num;
                            end
                            if (is_and_interlocked) begin
                                state_r <= S_DRAIN;
                            end else if (is_call_s || is_call_l) begin
                                // Push first so a pointer fault keeps the return PC
                                call_ind_r <= is_call_l && SRC_MODE == `MODE_STACK_INDIRECT;
                                tgt_r <= is_call_s ? PC + SRC_VAL : SRC_VAL;
                                MEM_WR <= 1'b1;
                                MEM_ADDR <= CUR_SP;
                                MEM_WDATA <= next_pc(PC, PARCELS, PREFIX_ACTIVE);
                                state_r <= S_CALL_PUSH;
                            end else if ((is_fill_s || is_fill_l) && !CSP_IS_ISP) begin
                                MEM_WR <= 1'b0;
                                MEM_ADDR <= fill_ind;
                                tgt_r <= tgt_now_r;
                                state_r <= fill_read ? S_FILL_TGT : S_FILL_DEC;
                            end else begin
                                // Interrupt stack fill is a no-op
                                PC <= next_pc(PC, PARCELS, PREFIX_ACTIVE);
                                PREFIX_ACTIVE <= 1'b0;
                                if (is_and_d || is_and_a) begin
                                    WB_VALID <= 1'b1;
                                    WB_TO_ACC <= is_and_a;
                                    WB_DATA <= and_res;
                                end
                                if (cmp[2])
                                    STATUS_FLAG <= rel_true;
                            end
                        end
                    end
                end
                S_DRAIN: begin
                    if (PIPE_EMPTY) begin
                        if (dmem_r) begin
                            MEM_WR <= 1'b0;
                            MEM_ADDR <= daddr_r;
                            MEM_LOCK <= 1'b1;
                            state_r <= S_LOCK_RD;
                        end else begin
                            WB_VALID <= 1'b1;
                            WB_TO_ACC <= 1'b0;
                            WB_DATA <= and_res;
                            state_r <= S_ACC_WB;
                        end
                    end
                end
                S_LOCK_RD: begin
                    if (MEM_ACK && MEM_FAULT) begin
                        MEM_LOCK <= 1'b0;
                        EXC_VALID <= 1'b1;
                        EXC_ID <= `EXC_READ_FAULT;
                        EXC_PC <= pc_exc;
                        PREFIX_ACTIVE <= 1'b0;
                        state_r <= S_IDLE;
                    end else if (MEM_ACK) begin
                        dst_r <= MEM_RDATA;
                        MEM_WR <= 1'b1;
                        MEM_WDATA <= and_res;
                        state_r <= S_LOCK_WR;
                    end
                end
                S_LOCK_WR: begin
                    if (MEM_ACK) begin
                        MEM_LOCK <= 1'b0;
                        state_r <= S_ACC_WB;
                    end
                end
                S_ACC_WB: begin
                    // Old value lands last, so an accumulator destination is unchanged
                    if (amem_r) begin
                        MEM_WR <= 1'b1;
                        MEM_ADDR <= aaddr_r;
                        MEM_WDATA <= dst_r;
                        state_r <= S_ACC_ST;
                    end else begin
                        WB_VALID <= 1'b1;
                        WB_TO_ACC <= 1'b1;
                        WB_DATA <= dst_r;
                        PC <= next_pc(PC, parcels_r, PREFIX_ACTIVE);
                        PREFIX_ACTIVE <= 1'b0;
                        state_r <= S_IDLE;
                    end
                end
                S_ACC_ST: begin
                    // Not restartable past here: a fault answer is ignored
                    if (MEM_ACK) begin
                        PC <= next_pc(PC, parcels_r, PREFIX_ACTIVE);
                        PREFIX_ACTIVE <= 1'b0;
                        state_r <= S_IDLE;
                    end
                end
                S_CALL_IND: begin
                    if (MEM_ACK && MEM_FAULT) begin
                        EXC_VALID <= 1'b1;
                        EXC_ID <= `EXC_READ_FAULT;
                        EXC_PC <= pc_exc;
                        PREFIX_ACTIVE <= 1'b0;
                        state_r <= S_IDLE;
                    end else if (MEM_ACK) begin
                        PC <= MEM_RDATA;
                        PREFIX_ACTIVE <= 1'b0;
                        state_r <= S_IDLE;
                    end
                end
                S_CALL_PUSH: begin
                    if (MEM_ACK && call_ind_r) begin
                        MEM_WR <= 1'b0;
                        MEM_ADDR <= tgt_r;
                        state_r <= S_CALL_IND;
                    end else if (MEM_ACK) begin
                        PC <= tgt_r;
                        PREFIX_ACTIVE <= 1'b0;
                        state_r <= S_IDLE;
                    end
                end
                S_FILL_TGT: begin
                    if (MEM_ACK && MEM_FAULT) begin
                        EXC_VALID <= 1'b1;
                        EXC_ID <= `EXC_READ_FAULT;
                        EXC_PC <= pc_exc;
                        PREFIX_ACTIVE <= 1'b0;
                        state_r <= S_IDLE;
                    end else if (MEM_ACK) begin
                        tgt_r <= tgt_round;
                        state_r <= S_FILL_DEC;
                    end
                end
                S_FILL_DEC: begin
                    // Limit below stack pointer is left to software
                    if (fill_go(msp_r, tgt_r, USER_SP)) begin
                        MEM_WR <= 1'b0;
                        MEM_ADDR <= msp_r;
                        cnt_r <= 2'h0;
                        state_r <= S_FILL_RD;
                    end else begin
                        PC <= next_pc(PC, parcels_r, PREFIX_ACTIVE);
                        PREFIX_ACTIVE <= 1'b0;
                        state_r <= S_IDLE;
                    end
                end
                S_FILL_RD: begin
                    if (MEM_ACK && MEM_FAULT) begin
                        EXC_VALID <= 1'b1;
                        EXC_ID <= `EXC_READ_FAULT;
                        EXC_PC <= pc_exc;
                        PREFIX_ACTIVE <= 1'b0;
                        state_r <= S_IDLE;
                    end else if (MEM_ACK) begin
                        CACHE_WE <= 1'b1;
                        CACHE_ADDR <= MEM_ADDR;
                        CACHE_DATA <= MEM_RDATA;
                        MEM_ADDR <= MEM_ADDR + `WORD_STEP;
                        cnt_r <= cnt_r + 2'h1;
                        if (cnt_r == `FILL_WORDS) begin
                            msp_r <= msp_r + `FILL_STEP;
                            state_r <= VIRT_EN ? S_FILL_CHK : S_FILL_DEC;
                        end
                    end
                end
                S_FILL_CHK: begin
                    if (CHK_OK) begin
                        state_r <= S_FILL_DEC;
                    end else begin
                        EXC_VALID <= 1'b1;
                        EXC_ID <= CHK_WALK_FAULT ? `EXC_WALK_FAULT : `EXC_READ_FAULT;
                        EXC_PC <= pc_exc;
                        PREFIX_ACTIVE <= 1'b0;
                        state_r <= S_IDLE;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### interlocked_logic_call_stack_fill_bench.sv
/* Bench: drives decoded instructions and mirrors every result.
   Assumes the memory partner answers all requests. */
`timescale 1ns/1ps
`default_nettype none
module interlocked_logic_call_stack_fill_bench;
    logic CLK = 1'b0, RST = 1'b1, CE = 1'b1, INSTR_VALID = 1'b0, DST_IN_MEM = 1'b0;
    logic ACC_IN_MEM = 1'b0, CSP_IS_ISP = 1'b0, FILL_LIMIT_LOAD = 1'b0, ENTER_DONE = 1'b0;
    logic [5:0] OPCODE = 6'h0;
    logic [3:0] SUBCODE = 4'h0, SRC_MODE = 4'hF, DST_MODE = 4'h0;
    logic [2:0] PARCELS = 3'h3;
    logic [31:0] SRC_VAL = 32'h0, DST_VAL = 32'h0, DST_ADDR = 32'h100, ACC_ADDR = 32'h200;
    logic [31:0] CUR_SP = 32'h80, USER_SP = 32'h0, FILL_LIMIT_VAL = 32'h0, lfsr = 32'hD773;
    logic [31:0] s, d, pc = 32'h0, xid, xpc, rsel, wq[$];
    logic [41:0] cops = {6'h13, 6'h12, 6'h11, 6'h10, 6'h1E, 6'h1D, 6'h1F};
    int failures = 0, cmp_count = 0, k;
    wire PIPE_EMPTY = 1'b1, VIRT_EN = 1'b0, CHK_OK = 1'b1, CHK_WALK_FAULT = 1'b0, FETCH_FAULT = 1'b0;
    wire INSTR_READY, MEM_REQ, MEM_WR, MEM_LOCK, MEM_ACK, MEM_FAULT, CACHE_WE, WB_VALID, WB_TO_ACC;
    wire STATUS_FLAG, ENTER_GUARD, PREFIX_ACTIVE, REG_ACCESS, EXC_VALID;
    wire [3:0] REG_SEL, EXC_ID;
    wire [31:0] MEM_ADDR, MEM_WDATA, MEM_RDATA, CACHE_ADDR, CACHE_DATA, FILL_LIMIT, WB_DATA, PC, EXC_PC;
    interlocked_logic_call_stack_fill #(.CACHE_CAPACITY(32'h40)) i_interlocked_logic_call_stack_fill (.*);
    memory_model i_memory_model (.*);
    function automatic logic [31:0] rnd(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task check(input logic [33:0] seen, input logic [33:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        if (failures == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task wait_idle;
        while (INSTR_READY !== 1'b1) @(posedge CLK);
    endtask
    task issue(input logic [5:0] op, input logic [3:0] sub, input logic [2:0] par, input logic [31:0] sv);
        wait_idle();
        {OPCODE, SUBCODE, PARCELS, SRC_VAL, DST_VAL, INSTR_VALID} <= {op, sub, par, sv, d, 1'b1};
        @(posedge CLK);
        INSTR_VALID <= 1'b0;
        @(posedge CLK);
        pc = pc + {28'h0, par, 1'b0};
    endtask
    initial forever #20 CLK = ~CLK;
    initial begin
        repeat (4000) @(posedge CLK);
        failures++;
        give_verdict();
    end
    // Address folded into data so one queue entry pins both
    always @(posedge CLK) begin
        if (MEM_REQ && MEM_WR && MEM_ACK) wq.push_back(MEM_ADDR ^ MEM_WDATA);
        if (EXC_VALID) {xid, xpc} <= {28'h0, EXC_ID, EXC_PC};
        if (REG_ACCESS) rsel <= {28'h0, REG_SEL};
        if (CACHE_WE)
            check({CACHE_ADDR >= 32'h40, CACHE_DATA ^ CACHE_ADDR}, 34'h05A5A0000);
    end
    initial begin
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        for (int i = 0; i < 17; i++) begin
            s = rnd(lfsr);
            d = i[1] ? s : rnd(s);
            lfsr = rnd(d);
            k = (i - 3) % 7;
            if (i < 3) begin
                issue(i == 0 ? 6'h22 : i == 1 ? 6'h32 : 6'h0E, 4'h0, i == 2 ? 3'h1 : 3'h3, s);
                check({WB_VALID, WB_TO_ACC, WB_DATA}, {1'b1, i != 0, s & d});
            end else begin
                issue(cops[6 * k +: 6], 4'h0, k < 3 ? 3'h3 : 3'h1, s);
                check({33'h0, STATUS_FLAG}, {33'h0, k == 2 ? s > d : k % 3 == 0 ? s == d
                    : $signed(s) > $signed(d)});
            end
        end
        ENTER_DONE <= 1'b1;
        @(posedge CLK);
        ENTER_DONE <= 1'b0;
        @(posedge CLK);
        check({33'h0, ENTER_GUARD}, 34'h1);
        issue(6'h0B, 4'hA, 3'h1, s);
        check({33'h0, ENTER_GUARD}, 34'h0);
        {DST_IN_MEM, ACC_IN_MEM} <= 2'h3;
        issue(6'h02, 4'h0, 3'h3, s);
        wait_idle();
        d = 32'h5A5A0100;
        check({2'h0, wq.pop_front()}, {2'h0, 32'h100 ^ (d & s)});
        check({2'h0, wq.pop_front()}, {2'h0, 32'h200 ^ d});
        issue(6'h00, 4'h1, 3'h3, 32'h400);
        wait_idle();
        check({2'h0, wq.pop_front()}, {2'h0, 32'h80 ^ pc});
        check({2'h0, PC}, 34'h400);
        pc = 32'h400;
        SRC_MODE <= 4'hD;
        issue(6'h00, 4'h1, 3'h3, 32'hFFFC);
        wait_idle();
        @(posedge CLK);
        check({2'h0, wq.pop_front()}, {2'h0, 32'h80 ^ pc});
        check({2'h0, xpc}, 34'h400);
        check({2'h0, xid}, 34'h8);
        SRC_MODE <= 4'hF;
        pc = 32'h400;
        for (int i = 0; i < 4; i++) begin
            // Reload keeps the limit at or above the user stack pointer
            {FILL_LIMIT_LOAD, FILL_LIMIT_VAL, CSP_IS_ISP} <= {1'b1, i == 3 ? 32'h10 : 32'h0, i == 3};
            @(posedge CLK);
            FILL_LIMIT_LOAD <= 1'b0;
            issue(i < 2 ? 6'h00 : 6'h02, i < 2 ? 4'h8 : 4'h1, i < 2 ? 3'h3 : 3'h1,
                i == 0 ? 32'h25 : i == 1 ? 32'h1000 : 32'h2);
            wait_idle();
            check({2'h0, FILL_LIMIT}, i == 0 ? 34'h30 : i == 1 ? 34'h40 : i == 2 ? 34'h20 : 34'h10);
        end
        {CSP_IS_ISP, DST_MODE, DST_ADDR} <= {1'b0, 4'h7, 32'hFFFFFFF0};
        for (int i = 0; i < 2; i++) begin
            s = pc;
            issue(6'h0B, 4'h0, 3'h1, s);
            issue(6'h22, 4'h0, 3'h3, s);
            repeat (2) @(posedge CLK);
            check({2'h0, i ? rsel : xid}, i ? 34'h5 : 34'h4);
            check({2'h0, i ? PC : xpc}, {2'h0, i ? s + 32'h8 : s});
            DST_ADDR <= 32'h000000A5;
            pc = i ? pc : s;
        end
        give_verdict();
    end
endmodule
`default_nettype wire

// ### interlocked_logic_call_stack_fill_map.vh
/*
 * Constants for the interlocked-logic, call, stack-fill and compare sequencer:
 * opcodes, subcodes, operand modes, exception identifiers and reset values.
 * Assumes inclusion by bare name from files that need these numbers.
 */
`ifndef INTERLOCKED_LOGIC_CALL_STACK_FILL_MAP_VH
`define INTERLOCKED_LOGIC_CALL_STACK_FILL_MAP_VH
`define OP_LONG0 6'h00
`define OP_CALL_SHORT 6'h01
`define OP_AND_LOCKED 6'h02
`define OP_ESCAPE 6'h0B
`define OP_AND_ACC_SHORT 6'h0E
`define OP_AND_SHORT 6'h0F
`define OP_AND_LONG 6'h22
`define OP_AND_ACC_LONG 6'h32
`define OP_CMP_EQ_IMM 6'h10
`define OP_CMP_GT_STK 6'h11
`define OP_CMP_GT_IMM 6'h12
`define OP_CMP_EQ_STK 6'h13
`define OP_CMP_GT 6'h1D
`define OP_CMP_HI 6'h1E
`define OP_CMP_EQ 6'h1F
`define SUB_CALL_LONG 4'h1
`define SUB_FILL_SHORT 4'h1
`define SUB_FILL_LONG 4'h8
`define SUB_CLEAR_GUARD 4'hA
`define SUB_PREFIX 4'h0
`define REL_EQ 2'h0
`define REL_GT 2'h1
`define REL_HI 2'h2
`define MODE_REGISTER 4'h7
`define MODE_STACK_OFFSET 4'h0
`define MODE_STACK_INDIRECT 4'hD
`define MODE_ABSOLUTE 4'hC
`define MODE_IMMEDIATE 4'hF
`define PARCELS_SHORT 3'h1
`define FILL_STEP 32'h00000010
`define FILL_WORDS 2'h3
`define WORD_STEP 32'h00000004
`define EXC_READ_FAULT 4'h8
`define EXC_WALK_FAULT 4'hB
`define EXC_FETCH_FAULT 4'h9
`define EXC_UNIMPLEMENTED 4'h4
`define PC_RESET 32'h00000000
`define FILL_LIMIT_RESET 32'h00000000
`endif

// ### memory_model.sv
/* Memory partner: acks alternately at once or a cycle late; one pointer address faults.
   Assumes requests are held until acked. */
`timescale 1ns/1ps
`default_nettype none
module memory_model (
    input wire logic CLK, RST, MEM_REQ,
    input wire logic [31:0] MEM_ADDR,
    output logic MEM_ACK, MEM_FAULT,
    output logic [31:0] MEM_RDATA
);
    logic fast_r, late_r;
    assign MEM_ACK = MEM_REQ & (fast_r | late_r);
    assign MEM_FAULT = (MEM_ADDR == 32'h0000FFFC);
    // Inverted off the ack cycle, so stale data never passes
    assign MEM_RDATA = {32{~MEM_ACK}} ^ MEM_ADDR ^ 32'h5A5A0000;
    always @(posedge CLK or posedge RST)
        if (RST) {fast_r, late_r} <= 2'h0;
        else {fast_r, late_r} <= {fast_r ^ MEM_ACK, MEM_REQ & ~MEM_ACK};
endmodule
`default_nettype wire

// ### sequencer_assertions.sv
/* Port checker for the instruction sequencer.
   Assumes one clock domain and a bind onto the top module. */
`timescale 1ns/1ps
`default_nettype none
`include "interlocked_logic_call_stack_fill_map.vh"
module sequencer_assertions #(parameter [31:0] CACHE_CAPACITY = 32'h00000100) (
    input wire logic CLK, RST, CE, INSTR_VALID, INSTR_READY, CSP_IS_ISP, FILL_LIMIT_LOAD,
    input wire logic MEM_REQ, MEM_ACK, MEM_WR, MEM_LOCK, WB_VALID, WB_TO_ACC, ENTER_DONE,
    input wire logic ENTER_GUARD, PREFIX_ACTIVE,
    input wire logic [5:0] OPCODE,
    input wire logic [3:0] SUBCODE,
    input wire logic [2:0] PARCELS,
    input wire logic [31:0] SRC_VAL, DST_VAL, USER_SP, MEM_ADDR, FILL_LIMIT, WB_DATA
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (RST);
    wire take = CE & INSTR_VALID & INSTR_READY;
    a_no_issue_busy: assert property (MEM_REQ |-> !INSTR_READY)
        else $error("instruction admitted during memory traffic");
    a_request_held: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
        else $error("memory request changed before ack");
    a_lock_on_read: assert property ($rose(MEM_LOCK) |-> MEM_REQ && !MEM_WR)
        else $error("lock raised off a destination read");
    a_lock_drop: assert property (MEM_LOCK && MEM_WR && MEM_ACK |=> !MEM_LOCK)
        else $error("lock held past final store");
    a_fill_step: assert property (
        FILL_LIMIT != $past(FILL_LIMIT) && !$past(FILL_LIMIT_LOAD) |-> FILL_LIMIT ==
        $past(FILL_LIMIT) + 32'h10 && FILL_LIMIT - USER_SP <= CACHE_CAPACITY)
        else $error("fill limit moved wrongly");
    a_isp_fill_noop: assert property (
        take && CSP_IS_ISP && OPCODE == `OP_AND_LOCKED && PARCELS == `PARCELS_SHORT
        |=> FILL_LIMIT == $past(FILL_LIMIT) && INSTR_READY)
        else $error("fill acted under interrupt stack");
    a_and_result: assert property (
        take && !PREFIX_ACTIVE && OPCODE == `OP_AND_LONG |=> WB_VALID && !WB_TO_ACC
        && WB_DATA == ($past(SRC_VAL) & $past(DST_VAL)))
        else $error("plain and result wrong");
    a_guard_clear: assert property (
        take && OPCODE == `OP_ESCAPE && SUBCODE == `SUB_CLEAR_GUARD && !ENTER_DONE
        |=> !ENTER_GUARD)
        else $error("enter guard not cleared");
endmodule
bind interlocked_logic_call_stack_fill sequencer_assertions
    #(.CACHE_CAPACITY(CACHE_CAPACITY)) i_check (.*);
`default_nettype wire
